// File: rsx_params.svh
// constants for the reset and exception sequencer
`ifndef RSX_PARAMS_SVH
`define RSX_PARAMS_SVH

// -----------------------------------------------------------------------------
// addresses and widths
// -----------------------------------------------------------------------------
`define RSX_ADDR_W        16
`define RSX_DATA_W        8
`define RSX_RESET_VEC_HI  16'h0000
`define RSX_RESET_VEC_LO  16'h0001
`define RSX_ZERO_ADDR     16'h0000
`define RSX_ZERO_DATA     8'h00

// -----------------------------------------------------------------------------
// condition flags word
// -----------------------------------------------------------------------------
`define RSX_CFW_RESET     8'h80
`define RSX_CFW_MASK_BIT  7

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define RSX_MIN_LOW_CYC   10
`define RSX_LOW_CNT_W     4

`endif

// File: rsx_pkg.sv
// types for the reset and exception sequencer
package rsx_pkg;
	// gray-coded sequencer states along the reset path
	typedef enum logic [2:0] {
		RSX_HOLD    = 3'b000,
		RSX_FETCH_H = 3'b001,
		RSX_FETCH_L = 3'b011,
		RSX_FIRST   = 3'b010,
		RSX_RUN     = 3'b110,
		RSX_IRQ     = 3'b111
	} rsx_state_t;
endpackage : rsx_pkg

// File: rsx_sequencer.sv
// reset and exception entry sequencer of the cpu
// limitation: the pin is seen two clocks late through the synchroniser,
// so the halt follows a falling pin by three clocks at the outputs.
// a low period shorter than the minimum is only flagged; the release
// still goes ahead, since refusing it would leave the core stuck
`timescale 1ns/1ps
`include "rsx_params.svh"

module rsx_sequencer #(
	parameter int MIN_LOW_CYC = `RSX_MIN_LOW_CYC
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// reset pin from the external source
	input  wire logic                      chip_clear_pin_n,
	// vector read port to program memory
	output logic                           vec_rd_reg,
	output logic [`RSX_ADDR_W-1:0]         vec_addr_reg,
	input  wire logic [`RSX_DATA_W-1:0]    vec_data,
	// cpu core handshake
	input  wire logic                      insn_done,
	input  wire logic                      irq_pending,
	input  wire logic                      cfw_mask_in,
	output logic                           core_halt_reg,
	output logic                           periph_init_reg,
	output logic                           cfw_set_mask_reg,
	output logic [`RSX_DATA_W-1:0]         cfw_init_reg,
	output logic                           pc_load_reg,
	output logic [`RSX_ADDR_W-1:0]         pc_value_reg,
	output logic                           irq_accept_reg,
	output logic                           short_reset_reg
);
	import rsx_pkg::*;

	// -------------------------------------------------------------------------
	// pin synchroniser
	// -------------------------------------------------------------------------
	logic                      sync1_reg;
	logic                      sync2_reg;
	rsx_state_t                state_reg;
	rsx_state_t                state_next;
	logic [`RSX_LOW_CNT_W-1:0] low_cnt_reg;
	logic [`RSX_DATA_W-1:0]    pc_hi_reg;
	logic                      pc_hi_en;

	// two flops; only sync2 is ever read by logic
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= chip_clear_pin_n;
			sync2_reg <= sync1_reg;
		end
	end

	// -------------------------------------------------------------------------
	// decode
	// -------------------------------------------------------------------------
	// a low pin wins over anything else in flight
	wire pin_low    = ~sync2_reg;
	wire low_ok     = (low_cnt_reg >= MIN_LOW_CYC[`RSX_LOW_CNT_W-1:0]);
	// mask from the flags word blocks entry but leaves flags pending
	wire irq_ok     = irq_pending & ~cfw_mask_in & insn_done;
	wire in_reset   = (state_reg == RSX_HOLD);

	// length of the low period; saturates so long holds do not wrap
	always_ff @(posedge clk) begin
		if (reset) begin
			low_cnt_reg <= '0;
		end else if (pin_low) begin
			if (!low_ok)
				low_cnt_reg <= low_cnt_reg + 1'b1;
		end else if (!in_reset) begin
			low_cnt_reg <= '0;
		end
	end

	// -------------------------------------------------------------------------
	// sequencer
	// -------------------------------------------------------------------------
	// reset exits to vector fetch in the very cycle the pin is seen high
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RSX_HOLD:    state_next = RSX_FETCH_H;
			RSX_FETCH_H: state_next = RSX_FETCH_L;
			RSX_FETCH_L: state_next = RSX_FIRST;
			// no interrupt can be taken until the first insn ends
			RSX_FIRST:   state_next = insn_done ? RSX_RUN : RSX_FIRST;
			RSX_RUN:     state_next = irq_ok ? RSX_IRQ : RSX_RUN;
			RSX_IRQ:     state_next = RSX_RUN;
			default:     state_next = RSX_HOLD;
		endcase
		if (pin_low)
			state_next = RSX_HOLD;
	end

	// the high vector byte is captured from the read port only in the first fetch
	assign pc_hi_en = (state_reg == RSX_FETCH_H);

	// state register; reset parks the sequencer in the reset state
	always_ff @(posedge clk) begin
		if (reset)
			state_reg <= RSX_HOLD;
		else
			state_reg <= state_next;
	end

	// high byte of the vector captured one cycle before the low one
	always_ff @(posedge clk) begin
		if (reset)
			pc_hi_reg <= `RSX_ZERO_DATA;
		else if (pc_hi_en)
			pc_hi_reg <= vec_data;
	end

	// -------------------------------------------------------------------------
	// output decode
	// -------------------------------------------------------------------------
	// states in which the vector bytes are on the read port
	function automatic logic rsx_is_fetch(input rsx_state_t st);
		return (st == RSX_FETCH_H) || (st == RSX_FETCH_L);
	endfunction : rsx_is_fetch

	// the core runs only in the first insn and in normal flow
	wire halt_next     = (state_next != RSX_RUN) && (state_next != RSX_FIRST);
	// peripherals stay in init for the whole reset state
	wire init_next     = (state_next == RSX_HOLD);
	// mask is forced from the reset state until the pc is loaded
	wire set_mask_next = init_next || rsx_is_fetch(state_next);
	wire fetch_next    = rsx_is_fetch(state_next);
	// high byte address first, low byte on the second fetch
	wire [`RSX_ADDR_W-1:0] addr_next = (state_next == RSX_FETCH_L) ? `RSX_RESET_VEC_LO
	                                                               : `RSX_RESET_VEC_HI;
	// a pin going low in the last fetch cancels the load
	wire load_next     = (state_reg == RSX_FETCH_L) && !pin_low;
	// entry is refused while the pin is low, even with a request
	wire accept_next   = (state_reg == RSX_RUN) && irq_ok && !pin_low;
	wire release_now   = in_reset && !pin_low;

	// -------------------------------------------------------------------------
	// registered outputs
	// -------------------------------------------------------------------------
	// core and peripheral control levels
	always_ff @(posedge clk) begin
		if (reset) begin
			core_halt_reg   <= 1'b1;
			periph_init_reg <= 1'b1;
		end else begin
			core_halt_reg   <= halt_next;
			periph_init_reg <= init_next;
		end
	end

	// flags word forcing; the init word never changes, only the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			cfw_set_mask_reg <= 1'b1;
			cfw_init_reg     <= `RSX_CFW_RESET;
		end else begin
			cfw_set_mask_reg <= set_mask_next;
			cfw_init_reg     <= `RSX_CFW_RESET;
		end
	end

	// vector read port
	always_ff @(posedge clk) begin
		if (reset) begin
			vec_rd_reg   <= 1'b0;
			vec_addr_reg <= `RSX_ZERO_ADDR;
		end else begin
			vec_rd_reg   <= fetch_next;
			vec_addr_reg <= addr_next;
		end
	end

	// pc load strobe; the value is taken only on the last fetch
	always_ff @(posedge clk) begin
		if (reset) begin
			pc_load_reg  <= 1'b0;
			pc_value_reg <= `RSX_ZERO_ADDR;
		end else begin
			pc_load_reg  <= load_next;
			if (state_reg == RSX_FETCH_L)
				pc_value_reg <= {pc_hi_reg, vec_data};
		end
	end

	// interrupt entry strobe
	always_ff @(posedge clk) begin
		if (reset)
			irq_accept_reg <= 1'b0;
		else
			irq_accept_reg <= accept_next;
	end

	// diagnostic only: a short low period does not stop the release
	always_ff @(posedge clk) begin
		if (reset)
			short_reset_reg <= 1'b0;
		else if (release_now)
			short_reset_reg <= !low_ok;
	end

endmodule : rsx_sequencer

// File: rsx_checker.sv
// port assertions for the reset and exception sequencer
`timescale 1ns/1ps
module rsx_checker (
	input wire logic        clk, reset, chip_clear_pin_n, insn_done, irq_pending, cfw_mask_in,
	input wire logic        vec_rd_reg, core_halt_reg, periph_init_reg, cfw_set_mask_reg,
	input wire logic        pc_load_reg, irq_accept_reg, short_reset_reg,
	input wire logic [15:0] vec_addr_reg, pc_value_reg,
	input wire logic [7:0]  vec_data, cfw_init_reg
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// high vector byte first, then the low one
	vec_order_a: assert property ($rose(vec_rd_reg) |-> vec_addr_reg == 16'h0000 ##1
		vec_addr_reg == 16'h0001) else $error("vector fetch order wrong");
	pc_value_a: assert property (pc_load_reg |-> pc_value_reg == {$past(vec_data, 2),
		$past(vec_data)}) else $error("pc not taken from vector bytes");
	halt_pin_a: assert property (!chip_clear_pin_n [*6] |-> core_halt_reg && periph_init_reg)
		else $error("pin low did not halt");
	mask_set_a: assert property (vec_rd_reg |-> cfw_set_mask_reg && cfw_init_reg == 8'h80)
		else $error("mask bit not forced");
	accept_gate_a: assert property (irq_accept_reg |-> $past(irq_pending && !cfw_mask_in && insn_done))
		else $error("interrupt taken when not allowed");
	reset_prio_a: assert property (periph_init_reg || vec_rd_reg |-> !irq_accept_reg)
		else $error("interrupt during reset handling");
	first_insn_a: assert property (pc_load_reg |=> !irq_accept_reg)
		else $error("interrupt before first instruction");
	prompt_start_a: assert property (not (chip_clear_pin_n && core_halt_reg && !vec_rd_reg) [*8])
		else $error("reset handling did not start");
	cover property (pc_load_reg);
	cover property (irq_accept_reg);
	cover property ($fell(chip_clear_pin_n));
endmodule : rsx_checker
bind rsx_sequencer rsx_checker i_chk (.*);

// File: rsx_reset_src.sv
// external reset source driving the active-low reset pin
`timescale 1ns/1ps
module rsx_reset_src (
	input wire logic clk,
	output logic     chip_clear_pin_n
);
	// low from power-up until the bench first releases it
	initial chip_clear_pin_n = 1'b0;
	// a shorter request is stretched, so no short pulse ever leaves here
	task automatic pulse(input int n);
		chip_clear_pin_n = 1'b0;
		repeat ((n < 10) ? 10 : n) @(posedge clk);
		#2 chip_clear_pin_n = 1'b1;
	endtask : pulse
endmodule : rsx_reset_src

// File: tb_top.sv
// bench for the reset and exception sequencer
`timescale 1ns/1ps
`include "rsx_params.svh"
module tb_top;
	logic        clk, reset, insn_done, irq_pending, cfw_mask_in, vec_rd_reg, core_halt_reg;
	logic        periph_init_reg, cfw_set_mask_reg, pc_load_reg, irq_accept_reg, short_reset_reg;
	logic [15:0] vec_addr_reg, pc_value_reg, vec;
	logic [7:0]  cfw_init_reg, vec_data;
	wire         chip_clear_pin_n;
	int          num_errors = 0;
	int          cmp_count = 0;
	// other addresses read a changing pattern, never the vector
	assign vec_data = (vec_addr_reg == 16'h0000) ? vec[15:8] :
		(vec_addr_reg == 16'h0001) ? vec[7:0] : ~vec_addr_reg[7:0];
	rsx_reset_src i_src (.clk(clk), .chip_clear_pin_n(chip_clear_pin_n));
	rsx_sequencer i_dut (.*);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step();
		@(posedge clk);
		#2;
	endtask : step
	task automatic tally_and_finish();
		if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// wait, bounded, for the pc load and judge what was loaded
	task automatic wait_load(input logic [15:0] v);
		int i;
		for (i = 0; i < 40 && pc_load_reg !== 1'b1; i++) begin
			chk(irq_accept_reg, 16'h0);
			step();
		end
		if (i == 40) num_errors++;
		if (i == 40) tally_and_finish();
		chk(pc_value_reg, v);
		chk({core_halt_reg, cfw_set_mask_reg}, 16'h0);
		chk(short_reset_reg, 16'h0);
	endtask : wait_load
	// release the pin at power-up, then wait for the load
	task automatic boot(input logic [15:0] v, input int n);
		vec = v;
		i_src.pulse(n);
		wait_load(v);
	endtask : boot
	// masked, then unmasked request after the first instruction
	task automatic s_irq();
		step();
		chk(irq_accept_reg, 16'h0);
		cfw_mask_in = 1'b1;
		insn_done = 1'b1;
		repeat (3) step();
		chk(irq_accept_reg, 16'h0);
		cfw_mask_in = 1'b0;
		step();
		insn_done = 1'b0;
		chk(irq_accept_reg, 16'h1);
		step();
		chk(irq_accept_reg, 16'h0);
	endtask : s_irq
	// reset while running with a request pending
	task automatic s_mid();
		vec = 16'hbeef;
		insn_done = 1'b1;
		i_src.pulse(10);
		chk({core_halt_reg, periph_init_reg}, 16'h3);
		insn_done = 1'b0;
		wait_load(16'hbeef);
	endtask : s_mid
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		reset = 1'b1;
		insn_done = 1'b0;
		irq_pending = 1'b1;
		cfw_mask_in = 1'b0;
		vec = 16'h1234;
		repeat (12) step();
		reset = 1'b0;
		boot(16'h1234, 10);
		s_irq();
		s_mid();
		s_irq();
		tally_and_finish();
	end
endmodule : tb_top
